// >>> pkg/spcs_pkg.sv
// Constants and types for the position capture and status block.
// Assumes a single 25 MHz clock domain.
package spcs_pkg;
  localparam int unsigned POS_W      = 32;
  localparam int unsigned FAULT_W    = 16;
  localparam int unsigned CLK_HZ     = 25000000;
  // Direction flags hold for this long after the last position change
  localparam int unsigned DIR_HOLD_MS = 500;
  localparam int unsigned DIR_HOLD_CYC = (CLK_HZ / 1000) * DIR_HOLD_MS;
  localparam int unsigned DIR_CNT_W  = 24;
  localparam logic [POS_W-1:0]   POS_ZERO   = 32'h0000_0000;
  localparam logic [POS_W-1:0]   POS_UPPER  = 32'h7fff_ffff;
  localparam logic [POS_W-1:0]   POS_LOWER  = 32'h8000_0000;
  localparam logic [FAULT_W-1:0] FAULT_NONE = 16'h0000;
  // Acknowledge style of the fault flag
  typedef enum logic {SPCS_ACK_EDGE, SPCS_ACK_LEVEL} spcs_ack_mode_t;
endpackage : spcs_pkg

// >>> hdl/spcs_edge_det.sv
// Rising and falling edge detector for one synchronous level.
// Assumes the input is already synchronous to i_mclk.
`timescale 1ns/1ps
module spcs_edge_det
(
  input  wire logic i_mclk,
  input  wire logic i_reset_n,
  input  wire logic i_level,
  output logic      o_rise,
  output logic      o_fall
);
  logic prev_r;

  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      prev_r <= 1'b0;
    else
      prev_r <= i_level;
  end

  assign o_rise = i_level & ~prev_r;
  assign o_fall = ~i_level & prev_r;
endmodule : spcs_edge_det

// >>> hdl/spcs_dir_timer.sv
// Direction status: moving flags that age out after the hold time.
// Assumes i_pos_change is a one-cycle pulse with the change direction.
`timescale 1ns/1ps
module spcs_dir_timer
  import spcs_pkg::*;
(
  input  wire logic i_mclk,
  input  wire logic i_reset_n,
  input  wire logic i_pos_change,
  input  wire logic i_pos_up,
  output logic      o_moving_positive,
  output logic      o_moving_negative
);
  logic [DIR_CNT_W-1:0] age_r;

  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      age_r <= '0;
    else if (i_pos_change)
      age_r <= DIR_CNT_W'(DIR_HOLD_CYC);
    else if (age_r != '0)
      age_r <= age_r - 1'b1;
  end

  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_moving_positive <= 1'b0;
      o_moving_negative <= 1'b0;
    end
    else if (i_pos_change)
    begin
      o_moving_positive <= i_pos_up;
      o_moving_negative <= ~i_pos_up;
    end
    else if (age_r == DIR_CNT_W'(1))
    begin
      o_moving_positive <= 1'b0;
      o_moving_negative <= 1'b0;
    end
  end
endmodule : spcs_dir_timer

// >>> hdl/spcs_top.sv
// Capture, event flag, fault and direction status for one position channel.
// Assumes all inputs are synchronous to i_mclk; position is signed.
// What this block does
// - While armed, a configured capture-input edge latches the position.
// - Falling edge of latch_arm disarms capture, even with no capture.
// - Latched position holds until the next capture event.
// - latch_valid sets on capture, clears only on latch_arm falling edge.
// - Version one: fault acknowledged on rising edge of fault_acknowledge.
// - Version two onward: fault acknowledged while acknowledge is high.
// - flag_acknowledge rising edge clears compare, zero and range flags.
// - module_ready high only when configured, ready and data valid.
// - Direction flags follow last change, drop after 0.5 s.
// - Compare event flag set when its output changes state.
// - zero_reached sets when position reaches or crosses zero.
// - upper_range_exceeded sets on passing upper limit moving up.
// - lower_range_exceeded sets on passing lower limit moving down.
// - Any error raises the fault flag and loads its number.
// - fault_number is 16 bits; zero means no error.
// - No new fault reported until the previous one is acknowledged.
`timescale 1ns/1ps
module spcs_top
  import spcs_pkg::*;
(
  input  wire logic                  i_mclk,
  input  wire logic                  i_reset_n,
  input  wire logic [POS_W-1:0]      i_encoder_position,
  input  wire logic                  i_position_update,
  input  wire logic                  i_capture_input,
  input  wire logic                  i_capture_on_fall,
  input  wire logic                  i_latch_arm,
  input  wire logic                  i_output_a,
  input  wire logic                  i_output_b,
  input  wire logic                  i_flag_acknowledge,
  input  wire logic                  i_fault_acknowledge,
  input  spcs_pkg::spcs_ack_mode_t   i_ack_mode,
  input  wire logic                  i_fault_raise,
  input  wire logic [FAULT_W-1:0]    i_fault_code,
  input  wire logic                  i_configured,
  input  wire logic                  i_hw_ready,
  input  wire logic                  i_data_valid,
  output logic [POS_W-1:0]           o_latched_position,
  output logic                       o_latch_valid,
  output logic                       o_compare_event_a,
  output logic                       o_compare_event_b,
  output logic                       o_zero_reached,
  output logic                       o_upper_range_exceeded,
  output logic                       o_lower_range_exceeded,
  output logic                       o_moving_positive,
  output logic                       o_moving_negative,
  output logic                       o_module_ready,
  output logic                       o_fault,
  output logic [FAULT_W-1:0]         o_fault_number
);
  import spcs_pkg::*;

  logic              cap_rise;
  logic              cap_fall;
  logic              arm_rise;
  logic              arm_fall;
  logic              eack_rise;
  logic              fack_rise;
  logic              outa_rise;
  logic              outa_fall;
  logic              outb_rise;
  logic              outb_fall;
  logic              armed_r;
  logic              cap_evt;
  logic [POS_W-1:0]  pos_prev_r;
  logic              pos_seen_r;
  logic              pos_change;
  logic              pos_up;
  logic              zero_hit;
  logic              upper_hit;
  logic              lower_hit;
  logic              wrap_hit;
  logic              fault_ack;

  spcs_edge_det u_cap_edge
  (
    .i_mclk    (i_mclk),
    .i_reset_n (i_reset_n),
    .i_level   (i_capture_input),
    .o_rise    (cap_rise),
    .o_fall    (cap_fall)
  );

  spcs_edge_det u_arm_edge
  (
    .i_mclk    (i_mclk),
    .i_reset_n (i_reset_n),
    .i_level   (i_latch_arm),
    .o_rise    (arm_rise),
    .o_fall    (arm_fall)
  );

  spcs_edge_det u_eack_edge
  (
    .i_mclk    (i_mclk),
    .i_reset_n (i_reset_n),
    .i_level   (i_flag_acknowledge),
    .o_rise    (eack_rise),
    .o_fall    ()
  );

  spcs_edge_det u_fack_edge
  (
    .i_mclk    (i_mclk),
    .i_reset_n (i_reset_n),
    .i_level   (i_fault_acknowledge),
    .o_rise    (fack_rise),
    .o_fall    ()
  );

  spcs_edge_det u_outa_edge
  (
    .i_mclk    (i_mclk),
    .i_reset_n (i_reset_n),
    .i_level   (i_output_a),
    .o_rise    (outa_rise),
    .o_fall    (outa_fall)
  );

  spcs_edge_det u_outb_edge
  (
    .i_mclk    (i_mclk),
    .i_reset_n (i_reset_n),
    .i_level   (i_output_b),
    .o_rise    (outb_rise),
    .o_fall    (outb_fall)
  );

  // Arming follows a rising level; a level already high at reset arms too
  // disarm on fall
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      armed_r <= 1'b0;
    else if (arm_fall || !i_latch_arm)
      armed_r <= 1'b0;
    else if (arm_rise || i_latch_arm)
      armed_r <= 1'b1;
  end

  assign cap_evt = armed_r && i_latch_arm &&
                   (i_capture_on_fall ? cap_fall : cap_rise);

  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_latched_position <= POS_ZERO;
    else if (cap_evt)
      o_latched_position <= i_encoder_position;
  end

  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_latch_valid <= 1'b0;
    else if (cap_evt)
      o_latch_valid <= 1'b1;
    else if (arm_fall)
      o_latch_valid <= 1'b0;
  end

  // Previous sample for direction, zero and range detection
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      pos_prev_r <= POS_ZERO;
      pos_seen_r <= 1'b0;
    end
    else if (i_position_update)
    begin
      pos_prev_r <= i_encoder_position;
      pos_seen_r <= 1'b1;
    end
  end

  // First sample after reset has no history, so it raises no events
  assign pos_change = i_position_update && pos_seen_r &&
                      (i_encoder_position != pos_prev_r);
  // A wrap keeps the direction of travel, not the sign of the jump
  assign pos_up     = upper_hit ||
                      (!lower_hit &&
                       ($signed(i_encoder_position) > $signed(pos_prev_r)));

  // A wrap flips the sign bit without passing zero
  // zero reach or cross
  assign zero_hit = pos_change && !wrap_hit &&
    ((i_encoder_position == POS_ZERO) ||
     (pos_prev_r[POS_W-1] != i_encoder_position[POS_W-1]));

  // Wrap past the end of the range shows as a jump across the sign limit
  // upper and lower limit wrap
  assign upper_hit = pos_change && (pos_prev_r == POS_UPPER) &&
                     (i_encoder_position == POS_LOWER);
  assign lower_hit = pos_change && (pos_prev_r == POS_LOWER) &&
                     (i_encoder_position == POS_UPPER);

  // Either range wrap
  assign wrap_hit  = upper_hit || lower_hit;

  // Set wins over an acknowledge in the same cycle
  // compare flags
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_compare_event_a <= 1'b0;
      o_compare_event_b <= 1'b0;
    end
    else
    begin
      if (outa_rise || outa_fall)
        o_compare_event_a <= 1'b1;
      else if (eack_rise)
        o_compare_event_a <= 1'b0;
      if (outb_rise || outb_fall)
        o_compare_event_b <= 1'b1;
      else if (eack_rise)
        o_compare_event_b <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_zero_reached         <= 1'b0;
      o_upper_range_exceeded <= 1'b0;
      o_lower_range_exceeded <= 1'b0;
    end
    else
    begin
      if (zero_hit)
        o_zero_reached <= 1'b1;
      else if (eack_rise)
        o_zero_reached <= 1'b0;
      if (upper_hit)
        o_upper_range_exceeded <= 1'b1;
      else if (eack_rise)
        o_upper_range_exceeded <= 1'b0;
      if (lower_hit)
        o_lower_range_exceeded <= 1'b1;
      else if (eack_rise)
        o_lower_range_exceeded <= 1'b0;
    end
  end

  spcs_dir_timer u_dir
  (
    .i_mclk            (i_mclk),
    .i_reset_n         (i_reset_n),
    .i_pos_change      (pos_change),
    .i_pos_up          (pos_up),
    .o_moving_positive (o_moving_positive),
    .o_moving_negative (o_moving_negative)
  );

  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_module_ready <= 1'b0;
    else
      o_module_ready <= i_configured & i_hw_ready & i_data_valid;
  end

  assign fault_ack = (i_ack_mode == SPCS_ACK_EDGE) ? fack_rise
                                                   : i_fault_acknowledge;

  // A fault pending acknowledge blocks newer ones; those are dropped
  // no fault at reset
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_fault        <= 1'b0;
      o_fault_number <= FAULT_NONE;
    end
    else if (!o_fault && i_fault_raise && i_fault_code != FAULT_NONE)
    begin
      o_fault        <= 1'b1;
      o_fault_number <= i_fault_code;
    end
    else if (o_fault && fault_ack)
    begin
      o_fault        <= 1'b0;
      o_fault_number <= FAULT_NONE;
    end
  end
endmodule : spcs_top

// >>> dv/spcs_top_props.sv
// Checker for the capture, event and fault ports of spcs_top.
// Assumes it is bound to spcs_top and sees only its ports.
`timescale 1ns/1ps
module spcs_props
  import spcs_pkg::*;
(
  input wire logic                i_mclk,
  input wire logic                i_reset_n,
  input wire logic                i_capture_input,
  input wire logic                i_latch_arm,
  input wire logic                i_output_a,
  input wire logic                i_flag_acknowledge,
  input wire logic                i_fault_acknowledge,
  input spcs_pkg::spcs_ack_mode_t i_ack_mode,
  input wire logic                i_fault_raise,
  input wire logic [FAULT_W-1:0]  i_fault_code,
  input wire logic                i_configured,
  input wire logic                i_hw_ready,
  input wire logic                i_data_valid,
  input wire logic [POS_W-1:0]    o_latched_position,
  input wire logic                o_latch_valid,
  input wire logic                o_compare_event_a,
  input wire logic                o_module_ready,
  input wire logic                o_fault,
  input wire logic [FAULT_W-1:0]  o_fault_number
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  property p_ready_set;
    i_configured && i_hw_ready && i_data_valid |=> o_module_ready;
  endproperty
  a_ready_set: assert property (p_ready_set) else $error("no ready");
  property p_ready_clr;
    !(i_configured && i_hw_ready && i_data_valid) |=> !o_module_ready;
  endproperty
  a_ready_clr: assert property (p_ready_clr) else $error("ready on");
  property p_cap_keep;
    $stable(i_capture_input) |=> $stable(o_latched_position);
  endproperty
  a_cap_keep: assert property (p_cap_keep) else $error("value moved");
  property p_valid_clr;
    $fell(i_latch_arm) |=> !o_latch_valid;
  endproperty
  a_valid_clr: assert property (p_valid_clr) else $error("valid kept");
  property p_valid_hold;
    o_latch_valid && i_latch_arm |=> o_latch_valid;
  endproperty
  a_valid_hold: assert property (p_valid_hold) else $error("valid lost");
  property p_cmp_set;
    $past(i_reset_n) && $changed(i_output_a) |=> ##[0:1] o_compare_event_a;
  endproperty
  a_cmp_set: assert property (p_cmp_set) else $error("no compare flag");
  property p_evt_clr;
    $rose(i_flag_acknowledge) && $stable(i_output_a)
      |=> !o_compare_event_a;
  endproperty
  a_evt_clr: assert property (p_evt_clr) else $error("flag not cleared");
  property p_fault_load;
    !o_fault && i_fault_raise && i_fault_code != FAULT_NONE
      |=> o_fault && o_fault_number == $past(i_fault_code);
  endproperty
  a_fault_load: assert property (p_fault_load) else $error("no fault");
  property p_fault_hold;
    o_fault && i_ack_mode == SPCS_ACK_EDGE && !$rose(i_fault_acknowledge)
      |=> o_fault && $stable(o_fault_number);
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault lost");
  property p_fault_edge;
    o_fault && i_ack_mode == SPCS_ACK_EDGE && $rose(i_fault_acknowledge)
      |=> !o_fault;
  endproperty
  a_fault_edge: assert property (p_fault_edge) else $error("edge ack");
  property p_fault_lvl;
    o_fault && i_ack_mode == SPCS_ACK_LEVEL && i_fault_acknowledge |=> !o_fault;
  endproperty
  a_fault_lvl: assert property (p_fault_lvl) else $error("level ack");
  c_cap: cover property ($rose(o_latch_valid));
  c_evt: cover property ($rose(i_flag_acknowledge) && o_compare_event_a);
  c_lvl: cover property (o_fault && i_ack_mode == SPCS_ACK_LEVEL);
endmodule : spcs_props
bind spcs_top spcs_props u_props
(
  .i_mclk              (i_mclk),
  .i_reset_n           (i_reset_n),
  .i_capture_input     (i_capture_input),
  .i_latch_arm         (i_latch_arm),
  .i_output_a          (i_output_a),
  .i_flag_acknowledge  (i_flag_acknowledge),
  .i_fault_acknowledge (i_fault_acknowledge),
  .i_ack_mode          (i_ack_mode),
  .i_fault_raise       (i_fault_raise),
  .i_fault_code        (i_fault_code),
  .i_configured        (i_configured),
  .i_hw_ready          (i_hw_ready),
  .i_data_valid        (i_data_valid),
  .o_latched_position  (o_latched_position),
  .o_latch_valid       (o_latch_valid),
  .o_compare_event_a   (o_compare_event_a),
  .o_module_ready      (o_module_ready),
  .o_fault             (o_fault),
  .o_fault_number      (o_fault_number)
);

// >>> dv/spcs_ctrl_model.sv
// Controller model: raises the event acknowledge on request.
// Assumes the five acknowledgeable flags arrive packed in one bus.
`timescale 1ns/1ps
module spcs_ctrl_model
(
  input  wire logic       i_mclk,
  input  wire logic       i_reset_n,
  input  wire logic       i_req,
  input  wire logic [4:0] i_flags,
  output logic            o_flag_acknowledge
);
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n) o_flag_acknowledge <= 1'b0;
    else if (i_req) o_flag_acknowledge <= 1'b1;
    else if (i_flags == 5'h00) o_flag_acknowledge <= 1'b0;
  end
endmodule : spcs_ctrl_model

// >>> dv/test_spcs_top.sv
// Self-checking bench for spcs_top with a controller model.
// Assumes a 25 MHz clock; direction age-out is not waited for.
`timescale 1ns/1ps
module test_spcs_top;
  import spcs_pkg::*;
  logic clk = 0, rst_n = 0, upd = 1, cin = 0, cfall = 0, arm = 0;
  logic oa = 0, ob = 0, fack = 0, fr = 0, cfg = 0, hw = 0, dv = 0, req = 0;
  logic [31:0] pos = 32'h0;
  logic [15:0] fc = 16'h0, fn;
  spcs_ack_mode_t fmode = SPCS_ACK_EDGE;
  logic [31:0] lp;
  logic lv, ca, cb, zr, ur, lr, mp, mn, rdy, flt, eack;
  int error_cnt = 0, n_tests = 0;
  always #20 clk = ~clk;
  spcs_top uut (.i_mclk(clk), .i_reset_n(rst_n), .i_encoder_position(pos),
    .i_position_update(upd), .i_capture_input(cin),
    .i_capture_on_fall(cfall), .i_latch_arm(arm), .i_output_a(oa),
    .i_output_b(ob), .i_flag_acknowledge(eack), .i_fault_acknowledge(fack),
    .i_ack_mode(fmode), .i_fault_raise(fr), .i_fault_code(fc),
    .i_configured(cfg), .i_hw_ready(hw), .i_data_valid(dv),
    .o_latched_position(lp), .o_latch_valid(lv), .o_compare_event_a(ca),
    .o_compare_event_b(cb), .o_zero_reached(zr),
    .o_upper_range_exceeded(ur), .o_lower_range_exceeded(lr),
    .o_moving_positive(mp), .o_moving_negative(mn), .o_module_ready(rdy),
    .o_fault(flt), .o_fault_number(fn));
  spcs_ctrl_model u_ctrl (.i_mclk(clk), .i_reset_n(rst_n), .i_req(req),
    .i_flags({ca, cb, zr, ur, lr}), .o_flag_acknowledge(eack));
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : cyc
  task chk(input bit ok, input string msg);
    n_tests++;
    if (!ok)
    begin
      error_cnt++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : chk
  task give_verdict;
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict
  task t_ready;
    for (int k = 0; k < 8; k++)
    begin
      {cfg, hw, dv} = k[2:0];
      cyc(2);
      chk(rdy === (k == 7), "ready");
    end
  endtask : t_ready
  task t_capture;
    arm = 1; cyc(3); pos = 32'h0000_1234; cyc(3); cin = 1; cyc(3);
    chk(lp === 32'h0000_1234 && lv === 1'b1, "capture rise");
    arm = 0; cyc(3);
    chk(lv === 1'b0 && lp === 32'h0000_1234, "disarm keeps");
    arm = 1; cfall = 1; pos = 32'h0000_5678; cyc(3); cin = 0; cyc(3);
    chk(lp === 32'h0000_5678 && lv === 1'b1, "capture fall");
    arm = 0; cyc(3); arm = 1; cyc(3); arm = 0; cyc(3);
    pos = 32'h0000_9abc; cin = 1; cyc(2); cin = 0; cyc(3);
    chk(lp === 32'h0000_5678 && lv === 1'b0, "disarmed");
  endtask : t_capture
  task t_ack;
    req = 1; cyc(1); req = 0; cyc(6);
    chk({ca, cb, zr, ur, lr, eack} === 6'h00, "event ack");
  endtask : t_ack
  task t_events;
    t_ack();
    pos = 32'h0000_0005; cyc(3); pos = 32'h0; cyc(3);
    chk(zr === 1'b1 && mn === 1'b1 && mp === 1'b0, "zero down");
    oa = 1; cyc(3);
    chk(ca === 1'b1 && cb === 1'b0, "compare a");
    ob = 1; cyc(3);
    chk(cb === 1'b1, "compare b");
    pos = 32'h7fff_ffff; cyc(3); pos = 32'h8000_0000; cyc(3);
    chk(ur === 1'b1 && mp === 1'b1, "upper");
    t_ack();
    pos = 32'h7fff_ffff; cyc(3);
    chk(lr === 1'b1 && ur === 1'b0 && mn === 1'b1, "lower");
    t_ack();
    upd = 0;
    pos = 32'h0;
    cyc(3);
    chk(zr === 1'b0, "no update");
    upd = 1;
    cyc(3);
    chk(zr === 1'b1 && mn === 1'b1, "zero late");
  endtask : t_events
  task t_fault;
    fr = 1; fc = 16'h80a1; cyc(1); fc = 16'h1111; cyc(3);
    chk(flt === 1'b1 && fn === 16'h80a1, "fault held");
    fr = 0; fack = 1; cyc(3);
    chk(flt === 1'b0 && fn === 16'h0000, "edge ack");
    fr = 1; fc = 16'h0042; cyc(1); fr = 0; cyc(3);
    chk(flt === 1'b1 && fn === 16'h0042, "held ack");
    fmode = SPCS_ACK_LEVEL; cyc(3);
    chk(flt === 1'b0 && fn === 16'h0000, "level ack");
    fack = 0; cyc(2);
  endtask : t_fault
  initial
  begin
    repeat (12) @(posedge clk);
    #2 rst_n = 1;
    cyc(1);
    chk({lv, ca, cb, zr, ur, lr, mp, mn, rdy, flt} === 10'h0, "reset");
    chk(lp === 32'h0 && fn === 16'h0, "reset values");
    t_ready();
    t_capture();
    t_events();
    t_fault();
    give_verdict();
  end
  initial
  begin
    repeat (2000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end
endmodule : test_spcs_top
